// ===== design/fdcp_regs.svh
// constants of the floppy drive control port: offsets, fields, resets, timing
// assumes the system clock runs at 25 MHz
`ifndef FDCP_REGS_SVH
`define FDCP_REGS_SVH

// ==========================================================================
// register offsets
`define FDCP_STAT_ADDR 8'h00
`define FDCP_CTL_ADDR 8'h04

// ==========================================================================
// control port fields
`define FDCP_CMD_MSB 2
`define FDCP_CMD_RST_PULSE 3'h0
`define FDCP_CMD_FAST_STEP 3'h1
`define FDCP_CMD_LATCH 3'h2
`define FDCP_HL3_MASK 8'h37
`define FDCP_HL3_VALUE 8'h02
`define FDCP_LATCH_MSB 4
`define FDCP_LATCH_LSB 1
`define FDCP_SEL_BIT 4
`define FDCP_HOLD_BIT 3
`define FDCP_LATCH_RST 4'h0

// ==========================================================================
// timing
`define FDCP_CLK_NS 40
`define FDCP_STEP_PULSE_NS 4000
`define FDCP_STEP_PULSE_CYC ((`FDCP_STEP_PULSE_NS + `FDCP_CLK_NS - 1) / `FDCP_CLK_NS)
`define FDCP_SPARE_PULSE_NS 1000
`define FDCP_SPARE_PULSE_CYC ((`FDCP_SPARE_PULSE_NS + `FDCP_CLK_NS - 1) / `FDCP_CLK_NS)
`define FDCP_READY_HOLD_US 200000
`define FDCP_READY_HOLD_CYC ((`FDCP_READY_HOLD_US * 1000 + `FDCP_CLK_NS - 1) / `FDCP_CLK_NS)
`define FDCP_XTAL_KHZ 4000
`define FDCP_SYS_KHZ 25000
`define FDCP_XTAL_STEP 16'd8000
`define FDCP_XTAL_MOD 16'd25000

`endif

// ===== design/fdcp_pkg.sv
// types shared by the floppy drive control port modules
// assumes nothing of its surroundings
package fdcp_pkg;
    typedef logic [7:0] fdcp_addr_t;
    typedef logic [7:0] fdcp_byte_t;

    // every pin that arrives from outside the clock domain
    typedef struct packed {
        logic step;
        logic step_direction;
        logic head_load;
        logic so_gate_a;
        logic so_gate_b;
        logic si_gate_a;
        logic si_gate_b;
        logic drive0_ready_n;
        logic drive1_ready_n;
        logic drive0_index_n;
        logic drive1_index_n;
        logic drive0_track0_n;
        logic drive1_track0_n;
        logic drive0_wfault_n;
        logic drive1_wfault_n;
        logic drive0_rdata_n;
        logic drive1_rdata_n;
        logic spare_trig_n;
        logic spare_trig_p;
        logic boot_opt;
        logic rst_src_hold;
        logic sel_src_latch;
        logic ready_src_line;
    } fdcp_pins_t;
endpackage

// ===== design/fdcp_if.sv
// carriers between the control port and its one-shots and boot image
// assumes all users share one clock
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// one-shot trigger and output
interface fdcp_os_if;
    logic trig_p;
    logic trig_n;
    logic q;
    modport os (input trig_p, input trig_n, output q);
    modport user (output trig_p, output trig_n, input q);
endinterface

// ==========================================================================
// boot image lookup
interface fdcp_rom_if;
    logic [4:0] addr;
    fdcp_pkg::fdcp_byte_t data;
    modport rom (input addr, output data);
    modport user (output addr, input data);
endinterface

`default_nettype wire

// ===== design/fdcp_oneshot.sv
// retriggerable one-shot with rising and falling trigger inputs
// assumes triggers come from flops on the same clock
`timescale 1ns/1ps
`default_nettype none

module fdcp_oneshot #(
    parameter int unsigned CYCLES = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // trigger and pulse
    fdcp_os_if.os os
);
    import fdcp_pkg::*;

    typedef struct packed {
        logic prev_p;
        logic prev_n;
        logic [23:0] cnt;
        logic q;
    } fdcp_os_st_t;

    localparam fdcp_os_st_t ST_RST = '{prev_p: 1'b0, prev_n: 1'b1, cnt: 24'h0, q: 1'b0};

    fdcp_os_st_t st_ff;
    fdcp_os_st_t nxt_st;
    logic trig;

    assign trig = (os.trig_p & ~st_ff.prev_p) | (~os.trig_n & st_ff.prev_n);
    assign os.q = st_ff.q;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.prev_p = os.trig_p;
        nxt_st.prev_n = os.trig_n;
        if (trig) begin
            nxt_st.q = 1'b1;
            nxt_st.cnt = 24'(CYCLES - 1);
        end else if (st_ff.cnt != 24'h0) begin
            nxt_st.cnt = st_ff.cnt - 24'h1;
        end else begin
            nxt_st.q = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ST_RST;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================================
    // checks
    os_trigger_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rst_n && clk_en && trig) |=> st_ff.q)
        else $error("one-shot did not fire on its trigger");
    os_expire_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !trig && st_ff.cnt == 24'h0) |=> !st_ff.q)
        else $error("one-shot output outlived its count");
endmodule

`default_nettype wire

// ===== design/fdcp_boot_rom.sv
// fixed 32-byte bootstrap image
// assumes the reader registers the byte it gets
`timescale 1ns/1ps
`default_nettype none

module fdcp_boot_rom (
    // lookup
    fdcp_rom_if.rom bus
);
    import fdcp_pkg::*;

    localparam fdcp_byte_t ROM_IMG [0:31] = '{
        8'hdb, 8'hfc, 8'haf, 8'h6f, 8'h67, 8'h3c, 8'hd3, 8'hfa,
        8'h3e, 8'h8c, 8'hd3, 8'hf8, 8'hdb, 8'hfc, 8'hb7, 8'hf2,
        8'h19, 8'h00, 8'hdb, 8'hfb, 8'h77, 8'h23, 8'hc3, 8'h0c,
        8'h00, 8'hdb, 8'hf8, 8'hb7, 8'hca, 8'h7d, 8'h00, 8'h76
    };

    assign bus.data = ROM_IMG[bus.addr];
endmodule

`default_nettype wire

// ===== design/fdcp_ctl.sv
// floppy drive control port: command decode, latch, step and head-load gating
// assumes one 25 MHz clock; drive and controller pins are asynchronous
//
// Overview of operation
// - step-out to the drive goes low only while both its gate inputs are high.
// - step-in to the drive goes low only while both its gate inputs are high.
// - each controller step starts a one-shot giving an active-high step pulse.
// - step direction is given twice, one copy low for inward, one low for outward.
// - a control write with low bits 001 gives a one-cycle high fast-step pulse.
// - a control write matching xx00x010 gives a high head-load-three enable.
// - the drive-set select picks drive zero status lines when low, drive one when high.
// - a control write with low bits 010 latches data bit 4 as the drive-set select.
// - a control write with low bits 000 gives one low reset pulse.
// - the inverse of latch bit 3 is given as a static reset hold level.
// - drive reset is asserted whenever master reset or the chosen reset control is low.
// - head-load-three is the NAND of its enable and the common head-load line.
// - a 4 MHz square wave is derived for the separator and controller timing.
// - with the boot option on after reset, reads return the 32-byte boot image.
// - the spare one-shot takes a falling and a rising trigger and drives high.
// - controller ready is the inverted drive ready, or an index-kept one-shot.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "fdcp_regs.svh"

module fdcp_ctl #(
    parameter int unsigned READY_HOLD_CYC = `FDCP_READY_HOLD_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // register port
    input wire fdcp_pkg::fdcp_addr_t reg_addr,
    input wire fdcp_pkg::fdcp_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output fdcp_pkg::fdcp_byte_t reg_rdata,
    // pins from controller, drives and jumpers
    input wire fdcp_pkg::fdcp_pins_t pins,
    // controller side outputs
    output logic step_pulse,
    output logic dir_in_low,
    output logic dir_out_low,
    output logic ctl_ready,
    output logic clk4_out,
    // drive side outputs
    output logic step_out_n,
    output logic step_in_n,
    output logic head_load_zero_n,
    output logic head_load_three_n,
    output logic drive_reset_n,
    // decoded port lines
    output logic fast_step,
    output logic hl3_en,
    output logic reset_pulse_n,
    output logic reset_hold,
    output logic drive_set,
    // selected drive status, active low
    output logic sel_ready_n,
    output logic sel_index_n,
    output logic sel_track0_n,
    output logic sel_wfault_n,
    output logic sel_rdata_n,
    // spare one-shot
    output logic spare_q
);
    import fdcp_pkg::*;

    typedef struct packed {
        fdcp_pins_t s1;
        fdcp_pins_t s2;
        logic [`FDCP_LATCH_MSB:`FDCP_LATCH_LSB] latch;
        logic fast_step;
        logic hl3_en;
        logic rst_pulse_n;
        logic step_out_n;
        logic step_in_n;
        logic dir_in_low;
        logic dir_out_low;
        logic drive_reset_n;
        logic hl_zero_n;
        logic hl_three_n;
        logic reset_hold;
        logic ready;
        logic [4:0] sel_status;
        logic boot_armed;
        logic boot_mode;
        logic [15:0] acc;
        logic clk4;
        fdcp_byte_t rdata;
    } fdcp_state_t;

    // active-low edge sources start idle high: no false edge after reset
    localparam fdcp_pins_t PINS_RST = '{spare_trig_n: 1'b1, drive0_index_n: 1'b1,
        drive1_index_n: 1'b1, default: 1'b0};

    localparam fdcp_state_t ST_RST = '{
        s1: PINS_RST, s2: PINS_RST, latch: `FDCP_LATCH_RST,
        fast_step: 1'b0, hl3_en: 1'b0, rst_pulse_n: 1'b1,
        step_out_n: 1'b1, step_in_n: 1'b1, dir_in_low: 1'b0, dir_out_low: 1'b1,
        drive_reset_n: 1'b0, hl_zero_n: 1'b1, hl_three_n: 1'b1, reset_hold: 1'b1,
        ready: 1'b0, sel_status: 5'h1f, boot_armed: 1'b1, boot_mode: 1'b0,
        acc: 16'h0, clk4: 1'b0, rdata: 8'h00
    };

    fdcp_state_t st_ff;
    fdcp_state_t nxt_st;

    logic ctl_wr;
    logic [`FDCP_CMD_MSB:0] cmd;
    logic sel_line;
    logic reset_ctl;
    logic [16:0] acc_sum;

    fdcp_os_if step_os ();
    fdcp_os_if spare_os ();
    fdcp_os_if ready_os ();
    fdcp_rom_if rom ();

    // ==========================================================================
    // one-shots and boot image
    assign step_os.trig_p = st_ff.s2.step;
    assign step_os.trig_n = 1'b1;
    assign spare_os.trig_p = st_ff.s2.spare_trig_p;
    assign spare_os.trig_n = st_ff.s2.spare_trig_n;
    assign ready_os.trig_p = 1'b0;
    assign ready_os.trig_n = st_ff.sel_status[3];
    assign rom.addr = reg_addr[4:0];

    fdcp_oneshot #(.CYCLES(`FDCP_STEP_PULSE_CYC)) u_step_os (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .os(step_os.os)
    );

    fdcp_oneshot #(.CYCLES(`FDCP_SPARE_PULSE_CYC)) u_spare_os (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .os(spare_os.os)
    );

    fdcp_oneshot #(.CYCLES(READY_HOLD_CYC)) u_ready_os (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .os(ready_os.os)
    );

    fdcp_boot_rom u_rom (
        .bus(rom.rom)
    );

    // ==========================================================================
    // decode
    assign ctl_wr = reg_wr && (reg_addr == `FDCP_CTL_ADDR);
    assign cmd = reg_wdata[`FDCP_CMD_MSB:0];
    assign sel_line = st_ff.s2.sel_src_latch ? st_ff.latch[`FDCP_SEL_BIT] : 1'b0;
    assign acc_sum = {1'b0, st_ff.acc} + {1'b0, `FDCP_XTAL_STEP};
    // hold level or pulse, as the jumper chooses
    assign reset_ctl = st_ff.s2.rst_src_hold ? st_ff.reset_hold : st_ff.rst_pulse_n;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pins;
        nxt_st.s2 = st_ff.s1;

        // drive gating
        nxt_st.step_out_n = ~(st_ff.s2.so_gate_a & st_ff.s2.so_gate_b);
        nxt_st.step_in_n = ~(st_ff.s2.si_gate_a & st_ff.s2.si_gate_b);
        nxt_st.dir_in_low = ~st_ff.s2.step_direction;
        nxt_st.dir_out_low = st_ff.s2.step_direction;
        nxt_st.hl_zero_n = ~st_ff.s2.head_load;
        nxt_st.hl_three_n = ~(st_ff.hl3_en & st_ff.s2.head_load);
        nxt_st.reset_hold = ~st_ff.latch[`FDCP_HOLD_BIT];
        // master reset forces this low through the async reset
        nxt_st.drive_reset_n = reset_ctl;

        // control port writes
        nxt_st.fast_step = 1'b0;
        nxt_st.hl3_en = 1'b0;
        nxt_st.rst_pulse_n = 1'b1;
        if (ctl_wr) begin
            if (cmd == `FDCP_CMD_FAST_STEP) begin
                nxt_st.fast_step = 1'b1;
            end else if (cmd == `FDCP_CMD_RST_PULSE) begin
                nxt_st.rst_pulse_n = 1'b0;
            end else if (cmd == `FDCP_CMD_LATCH) begin
                nxt_st.latch = reg_wdata[`FDCP_LATCH_MSB:`FDCP_LATCH_LSB];
            end
            // other codes leave pulses idle and the latch alone
            if ((reg_wdata & `FDCP_HL3_MASK) == `FDCP_HL3_VALUE) begin
                nxt_st.hl3_en = 1'b1;
            end
            nxt_st.boot_armed = 1'b0;
            nxt_st.boot_mode = 1'b0;
        end else if (st_ff.boot_armed) begin
            nxt_st.boot_mode = st_ff.s2.boot_opt;
        end

        // drive status select
        if (sel_line) begin
            nxt_st.sel_status = {st_ff.s2.drive1_ready_n, st_ff.s2.drive1_index_n,
                st_ff.s2.drive1_track0_n, st_ff.s2.drive1_wfault_n,
                st_ff.s2.drive1_rdata_n};
        end else begin
            nxt_st.sel_status = {st_ff.s2.drive0_ready_n, st_ff.s2.drive0_index_n,
                st_ff.s2.drive0_track0_n, st_ff.s2.drive0_wfault_n,
                st_ff.s2.drive0_rdata_n};
        end

        // ready for the controller
        if (st_ff.s2.ready_src_line) begin
            nxt_st.ready = ~st_ff.sel_status[4];
        end else begin
            nxt_st.ready = ready_os.q;
        end

        // 4 MHz square wave: toggle at 8 MHz average by phase accumulation
        if (acc_sum >= {1'b0, `FDCP_XTAL_MOD}) begin
            nxt_st.acc = 16'(acc_sum - {1'b0, `FDCP_XTAL_MOD});
            nxt_st.clk4 = ~st_ff.clk4;
        end else begin
            nxt_st.acc = acc_sum[15:0];
        end

        // register read, data in the next cycle only
        nxt_st.rdata = 8'h00;
        if (reg_rd) begin
            if (st_ff.boot_mode) begin
                nxt_st.rdata = rom.data;
            end else if (reg_addr == `FDCP_STAT_ADDR) begin
                nxt_st.rdata = {st_ff.latch, st_ff.boot_mode, st_ff.sel_status[3],
                    st_ff.sel_status[2], st_ff.ready};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ST_RST;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================================
    // outputs
    assign reg_rdata = st_ff.rdata;
    assign step_pulse = step_os.q;
    assign spare_q = spare_os.q;
    assign dir_in_low = st_ff.dir_in_low;
    assign dir_out_low = st_ff.dir_out_low;
    assign ctl_ready = st_ff.ready;
    assign clk4_out = st_ff.clk4;
    assign step_out_n = st_ff.step_out_n;
    assign step_in_n = st_ff.step_in_n;
    assign head_load_zero_n = st_ff.hl_zero_n;
    assign head_load_three_n = st_ff.hl_three_n;
    assign drive_reset_n = st_ff.drive_reset_n;
    assign fast_step = st_ff.fast_step;
    assign hl3_en = st_ff.hl3_en;
    assign reset_pulse_n = st_ff.rst_pulse_n;
    assign reset_hold = st_ff.reset_hold;
    assign drive_set = st_ff.latch[`FDCP_SEL_BIT];
    assign sel_ready_n = st_ff.sel_status[4];
    assign sel_index_n = st_ff.sel_status[3];
    assign sel_track0_n = st_ff.sel_status[2];
    assign sel_wfault_n = st_ff.sel_status[1];
    assign sel_rdata_n = st_ff.sel_status[0];

    // ==========================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence ctl_write_s(logic [2:0] code);
        clk_en && reg_wr && reg_addr == `FDCP_CTL_ADDR && reg_wdata[2:0] == code;
    endsequence

    step_out_gate_a: assert property (rst_n && clk_en |=>
        step_out_n == !($past(st_ff.s2.so_gate_a) && $past(st_ff.s2.so_gate_b)))
        else $error("step-out does not follow its gates");
    step_in_gate_a: assert property (rst_n && clk_en |=>
        step_in_n == !($past(st_ff.s2.si_gate_a) && $past(st_ff.s2.si_gate_b)))
        else $error("step-in does not follow its gates");
    dir_pair_a: assert property (dir_in_low != dir_out_low)
        else $error("direction copies not complementary");
    fast_step_a: assert property (ctl_write_s(`FDCP_CMD_FAST_STEP) |=> fast_step
        ##1 (!fast_step || $past(ctl_wr)))
        else $error("fast step pulse wrong");
    hl3_enable_a: assert property ((clk_en && ctl_wr &&
        (reg_wdata & `FDCP_HL3_MASK) == `FDCP_HL3_VALUE) |=> hl3_en)
        else $error("head-load-three enable missing");
    drive_set_a: assert property (ctl_write_s(`FDCP_CMD_LATCH) |=>
        drive_set == $past(reg_wdata[`FDCP_SEL_BIT]))
        else $error("drive-set bit not latched");
    reset_pulse_a: assert property (ctl_write_s(`FDCP_CMD_RST_PULSE) |=> !reset_pulse_n)
        else $error("reset pulse missing");
    latch_keep_a: assert property ((clk_en && ctl_wr && cmd != `FDCP_CMD_LATCH) |=>
        $stable(st_ff.latch) && ($past(cmd) == `FDCP_CMD_FAST_STEP || !fast_step))
        else $error("unmatched write disturbed the port");
    drive_reset_a: assert property (rst_n && clk_en |=> drive_reset_n == $past(reset_ctl))
        else $error("drive reset does not follow its control");
    status_mux_a: assert property (rst_n && clk_en && !sel_line |=>
        sel_ready_n == $past(st_ff.s2.drive0_ready_n))
        else $error("drive zero status not selected");

    // ==========================================================================
    // checks of levels, reset path and boot reads
    sequence drive_pulse_s;
        rst_n && clk_en && !reset_pulse_n && !st_ff.s2.rst_src_hold;
    endsequence

    sequence line_ready_s;
        rst_n && clk_en && st_ff.s2.ready_src_line;
    endsequence

    dir_follow_a: assert property (rst_n && clk_en |=>
        dir_out_low == $past(st_ff.s2.step_direction))
        else $error("direction copy does not follow the controller");
    status_one_a: assert property (rst_n && clk_en && sel_line |=>
        sel_ready_n == $past(st_ff.s2.drive1_ready_n))
        else $error("drive one status not selected");
    reset_hold_a: assert property (rst_n && clk_en |=>
        reset_hold == !$past(st_ff.latch[`FDCP_HOLD_BIT]))
        else $error("reset hold level is not the inverted latch bit");
    pulse_reset_a: assert property (drive_pulse_s |=> !drive_reset_n)
        else $error("reset pulse did not reach the drive");
    hl3_gate_a: assert property (rst_n && clk_en |=>
        head_load_three_n == !($past(hl3_en) && $past(st_ff.s2.head_load)))
        else $error("head-load-three is not the nand of its gates");
    clk4_toggle_a: assert property (rst_n && clk_en &&
        acc_sum >= {1'b0, `FDCP_XTAL_MOD} |=> clk4_out == !$past(clk4_out))
        else $error("square wave missed a toggle");
    boot_read_a: assert property (rst_n && clk_en && reg_rd && st_ff.boot_mode |=>
        reg_rdata == $past(rom.data))
        else $error("boot byte not returned");
    ready_line_a: assert property (line_ready_s |=> ctl_ready == !$past(sel_ready_n))
        else $error("ready does not follow the drive line");
endmodule

`default_nettype wire

// ===== sim/fdcp_drive_model.sv
// two floppy drives as seen from the control port: status lines only
// assumes one clock shared with the board; all lines active low
`timescale 1ns/1ps
`default_nettype none

module fdcp_drive_model #(
    parameter int unsigned INDEX_PERIOD = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // ready, index, track0, wfault, rdata; drive zero then drive one
    output logic [9:0] drv
);
    logic [7:0] tick_ff;
    logic rdata_ff;

    // =====================================================================
    // index and read data timing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_ff <= 8'h00;
            rdata_ff <= 1'b0;
        end else begin
            tick_ff <= (tick_ff == 8'(INDEX_PERIOD - 1)) ? 8'h00 : tick_ff + 8'h01;
            rdata_ff <= ~rdata_ff;
        end
    end

    // drive zero spins at track zero; drive one idle, not ready, faulted
    assign drv = {1'b0, 1'b1, (tick_ff >= 8'h02), 1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
                  rdata_ff, 1'b1};
endmodule

`default_nettype wire

// ===== sim/tb_floppy_drive_control_port.sv
// self-checking bench for the floppy drive control port
// assumes the drive model stands on the drive side; clk_en held high
`timescale 1ns/1ps
`default_nettype none
`include "fdcp_regs.svh"

module tb_floppy_drive_control_port;
    import fdcp_pkg::*;

    typedef struct packed {
        logic [7:0] d;
        logic fast;
        logic rpn;
        logic hl3;
        logic ds;
        logic rh;
    } fdcp_row_t;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    fdcp_addr_t reg_addr = 8'h00;
    fdcp_byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    fdcp_byte_t reg_rdata;
    logic step = 1'b0, sdir = 1'b0, hload = 1'b0;
    logic so_a = 1'b0, so_b = 1'b0, si_a = 1'b0, si_b = 1'b0;
    logic sp_n = 1'b1, sp_p = 1'b0, boot = 1'b1, hold = 1'b1, sel_src = 1'b1, rdy_src = 1'b1;
    logic [9:0] drv;
    fdcp_pins_t pins;
    logic step_pulse, dir_in_low, dir_out_low, ctl_ready, clk4_out;
    logic step_out_n, step_in_n, head_load_zero_n, head_load_three_n, drive_reset_n;
    logic fast_step, hl3_en, reset_pulse_n, reset_hold, drive_set;
    logic sel_ready_n, sel_index_n, sel_track0_n, sel_wfault_n, sel_rdata_n, spare_q;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    fdcp_row_t rows [9];

    assign pins = {step, sdir, hload, so_a, so_b, si_a, si_b, drv,
                   sp_n, sp_p, boot, hold, sel_src, rdy_src};

    always #20 clk = ~clk;

    fdcp_drive_model drives (.clk(clk), .rst_n(rst_n), .drv(drv));

    fdcp_ctl #(.READY_HOLD_CYC(50)) dut (
        .clk(clk), .rst_n(rst_n), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pins(pins),
        .step_pulse(step_pulse), .dir_in_low(dir_in_low), .dir_out_low(dir_out_low),
        .ctl_ready(ctl_ready), .clk4_out(clk4_out),
        .step_out_n(step_out_n), .step_in_n(step_in_n),
        .head_load_zero_n(head_load_zero_n), .head_load_three_n(head_load_three_n),
        .drive_reset_n(drive_reset_n), .fast_step(fast_step), .hl3_en(hl3_en),
        .reset_pulse_n(reset_pulse_n), .reset_hold(reset_hold), .drive_set(drive_set),
        .sel_ready_n(sel_ready_n), .sel_index_n(sel_index_n), .sel_track0_n(sel_track0_n),
        .sel_wfault_n(sel_wfault_n), .sel_rdata_n(sel_rdata_n), .spare_q(spare_q)
    );

    // =====================================================================
    // bus cycles and comparison
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("err_count=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // =====================================================================
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // =====================================================================
    // main sequence
    initial begin
        logic [7:0] q;
        int n;
        logic prev;
        rows = '{
            '{8'h01, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1}, '{8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
            '{8'h1a, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0}, '{8'h05, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0},
            '{8'h07, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0}, '{8'hc2, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1},
            '{8'h0a, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0}, '{8'h22, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1},
            '{8'h03, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1}};
        cyc(2);
        chk({step_out_n, step_in_n, drive_reset_n, drive_set, reset_hold}, 8'h19);
        @(posedge clk);
        @(posedge clk);
        rst_n <= 1'b1;
        cyc(6);
        // boot image until the first control write
        rd(8'h00, q);
        chk(q, 8'hdb);
        rd(8'h01, q);
        chk(q, 8'hfc);
        rd(8'h10, q);
        chk(q, 8'h19);
        rd(8'h1f, q);
        chk(q, 8'h76);
        for (int i = 0; i < 9; i++) begin
            wr(8'h04, rows[i].d);
            chk(fast_step, rows[i].fast);
            chk(reset_pulse_n, rows[i].rpn);
            chk(hl3_en, rows[i].hl3);
            chk(drive_set, rows[i].ds);
            cyc(1);
            chk({fast_step, reset_pulse_n, hl3_en}, 8'h02);
            chk(reset_hold, rows[i].rh);
            cyc(1);
            chk(drive_reset_n, rows[i].rh);
        end
        rd(8'h00, q);
        chk(q[7:3], 8'h02);
        rd(8'h04, q);
        chk(q, 8'h00);
        // pulsed drive reset
        hold <= 1'b0;
        cyc(5);
        wr(8'h04, 8'h00);
        cyc(1);
        chk(drive_reset_n, 8'h00);
        cyc(1);
        chk(drive_reset_n, 8'h01);
        // step gates and direction copies
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {so_a, so_b} <= 2'(i);
            {si_a, si_b} <= ~2'(i);
            sdir <= i[0];
            cyc(5);
            chk(step_out_n, (i == 3) ? 8'h00 : 8'h01);
            chk(step_in_n, (i == 0) ? 8'h00 : 8'h01);
            chk({dir_in_low, dir_out_low}, {6'h00, ~i[0], i[0]});
        end
        // head load three gated by the one-cycle enable pulse
        hload <= 1'b1;
        cyc(5);
        chk(head_load_zero_n, 8'h00);
        wr(8'h04, 8'h02);
        cyc(1);
        chk(head_load_three_n, 8'h00);
        cyc(1);
        chk(head_load_three_n, 8'h01);
        // drive set select and ready sources
        wr(8'h04, 8'h12);
        cyc(5);
        chk({sel_ready_n, sel_track0_n, sel_wfault_n}, 8'h06);
        chk(ctl_ready, 8'h00);
        rdy_src <= 1'b0;
        cyc(100);
        chk(ctl_ready, 8'h00);
        wr(8'h04, 8'h02);
        cyc(100);
        chk({sel_ready_n, sel_track0_n, sel_wfault_n}, 8'h01);
        chk(ctl_ready, 8'h01);
        rdy_src <= 1'b1;
        cyc(6);
        chk(ctl_ready, 8'h01);
        // step one-shot
        step <= 1'b1;
        cyc(6);
        chk(step_pulse, 8'h01);
        step <= 1'b0;
        cyc(104);
        chk(step_pulse, 8'h00);
        // spare one-shot, falling then rising trigger
        sp_n <= 1'b0;
        cyc(6);
        chk(spare_q, 8'h01);
        cyc(30);
        chk(spare_q, 8'h00);
        sp_n <= 1'b1;
        sp_p <= 1'b1;
        cyc(6);
        chk(spare_q, 8'h01);
        cyc(30);
        chk(spare_q, 8'h00);
        // 4 MHz square: 40 rising edges in 10 us
        n = 0;
        prev = clk4_out;
        repeat (250) begin
            cyc(1);
            if (clk4_out === 1'b1 && prev === 1'b0) begin
                n++;
            end
            prev = clk4_out;
        end
        chk((n >= 39 && n <= 41) ? 8'h01 : 8'h00, 8'h01);
        tally_and_finish();
    end
endmodule

`default_nettype wire
